/* rtl/ebr_pkg.sv */
// Package: register map, field positions, reset values and widths
package ebr_pkg;

  // ---------------------------------------------------------------------
  // Register byte addresses on APB
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] WAITST_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // ---------------------------------------------------------------------
  // Control register field positions
  // ---------------------------------------------------------------------
  localparam int CTRL_MUX_BIT   = 0;  // Multiplexed bus mode
  localparam int CTRL_TRI_BIT   = 1;  // Tristate-time waitstate enable
  localparam int CTRL_RWD_BIT   = 2;  // Read/write command delay
  localparam int CTRL_ASYNC_BIT = 3;  // Ready taken through synchroniser
  localparam int CTRL_W         = 4;

  // ---------------------------------------------------------------------
  // Status register field positions
  // ---------------------------------------------------------------------
  localparam int STAT_REL_BIT   = 0;  // Bus handed to other master
  localparam int STAT_BUSY_BIT  = 1;  // Own bus cycle running
  localparam int STAT_BUS_REGAIN_REQUEST_BIT  = 2;  // Regain request driven
  localparam int STAT_HOLD_BIT  = 3;  // Hold request seen

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int WS_W   = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [WS_W-1:0]   WAITST_RST = 4'h0;

  // ---------------------------------------------------------------------
  // Bus cycle states, each lasting at least one output clock period
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_DLY, ST_WAIT, ST_RDY, ST_MUXW, ST_TRIW,
    ST_REL, ST_REGAIN
  } ebr_state_t;

endpackage : ebr_pkg

/* rtl/ebr_ready_sync.sv */
// Ready input path: direct or through a two-stage synchroniser
`timescale 1ns/1ps
module ebr_ready_sync (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic async_sel_in,
  input  wire logic ready_n_in,
  output logic      ready_n_out
);

  logic sync1_ff;
  logic sync2_ff;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= ready_n_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Asynchronous ready uses the synchronised copy
  assign ready_n_out = async_sel_in ? sync2_ff : ready_n_in;

endmodule : ebr_ready_sync

/* rtl/ebr_bus_ctrl.sv */
// External bus controller: ready termination, waitstates, hold arbitration
//
// Contract
// - Ready high at sampling point adds a waitstate; ready low ends cycle.
// - Unsynchronised ready must stay low long enough to be synchronised.
// - Multiplexed mode appends a waitstate; tristate waitstate optional there.
// - Gap is two output clocks muxed with tristate, zero demuxed without.
// - Each cycle is stretched by the programmed memory waitstates.
// - Command leading edge is delayed when read/write delay is set.
// - Hold request waits for the running cycle before acknowledging.
// - Released bus leaves chip selects undriven, pulled high outside.
// - Regaining starts only when hold request goes high.
// - Hold may drop without a regain request; ownership resumes normally.
// - Hold sampled, acknowledge and regain request changed on output clock.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module ebr_bus_ctrl (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_b_in,
  // APB slave
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [7:0]                paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  // Core request port
  input  wire logic                      req_in,
  input  wire logic                      req_wr_in,
  input  wire logic [ebr_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [ebr_pkg::DATA_W-1:0] req_wdata_in,
  output logic                           req_done_out,
  output logic [ebr_pkg::DATA_W-1:0]     req_rdata_out,
  // External bus pins
  output logic                           system_clock_output_out,
  output logic                           chip_select_line_n_out,
  output logic                           chip_select_line_oe_out,
  output logic                           cmd_read_n_out,
  output logic                           cmd_write_n_out,
  output logic                           addr_latch_en_out,
  output logic                           ctrl_oe_out,
  output logic [ebr_pkg::ADDR_W-1:0]     ext_addr_out,
  output logic                           ext_addr_oe_out,
  input  wire logic [ebr_pkg::DATA_W-1:0] ext_data_in,
  output logic [ebr_pkg::DATA_W-1:0]     ext_data_out,
  output logic                           ext_data_oe_out,
  input  wire logic                      ready_n_in,
  input  wire logic                      hold_n_in,
  output logic                           bus_release_acknowledge_n_out,
  output logic                           bus_regain_request_n_out
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic                          rst_s1_ff;
  logic                          rst_s2_ff;
  logic                          phase_ff;
  logic                          step;
  logic [ebr_pkg::CTRL_W-1:0]    ctrl_ff;
  logic [ebr_pkg::WS_W-1:0]      waitst_ff;
  logic [31:0]                   prdata_ff;
  logic                          pslverr_ff;
  ebr_pkg::ebr_state_t           state_ff;
  ebr_pkg::ebr_state_t           nxt_state;
  logic [ebr_pkg::WS_W-1:0]      ws_cnt_ff;
  logic                          wr_ff;
  logic [ebr_pkg::ADDR_W-1:0]    addr_ff;
  logic [ebr_pkg::DATA_W-1:0]    wdata_ff;
  logic [ebr_pkg::DATA_W-1:0]    rdata_ff;
  logic                          done_ff;
  logic                          hold_ff;
  logic                          bus_release_acknowledge_n_ff;
  logic                          bus_regain_request_n_ff;
  logic                          ready_n;
  logic                          setup;
  logic                          cmd_on;
  logic                          released;

  // Address decode, true for mapped word addresses
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ebr_pkg::CTRL_OFS) || (a == ebr_pkg::WAITST_OFS) ||
             (a == ebr_pkg::STATUS_OFS);
  endfunction : mapped

  // -----------------------------------------------------------------------
  // Reset release and output clock
  // -----------------------------------------------------------------------
  // Reset released through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // Output clock is system clock halved; step ends each output period
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  assign step                    = phase_ff;
  assign system_clock_output_out = phase_ff;

  // -----------------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------------
  assign setup       = psel_in && !penable_in;
  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_ff;
  assign pslverr_out = pslverr_ff;

  // Configuration registers written in the access phase
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      ctrl_ff   <= ebr_pkg::CTRL_RST;
      waitst_ff <= ebr_pkg::WAITST_RST;
    end else if (psel_in && penable_in && pwrite_in) begin
      if (paddr_in == ebr_pkg::CTRL_OFS) begin
        ctrl_ff <= pwdata_in[ebr_pkg::CTRL_W-1:0];
      end
      if (paddr_in == ebr_pkg::WAITST_OFS) begin
        waitst_ff <= pwdata_in[ebr_pkg::WS_W-1:0];
      end
    end
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !mapped(paddr_in);
      prdata_ff  <= 32'h0000_0000;
      case (paddr_in)
        ebr_pkg::CTRL_OFS: begin
          prdata_ff[ebr_pkg::CTRL_W-1:0] <= ctrl_ff;
        end
        ebr_pkg::WAITST_OFS: begin
          prdata_ff[ebr_pkg::WS_W-1:0] <= waitst_ff;
        end
        ebr_pkg::STATUS_OFS: begin
          prdata_ff[ebr_pkg::STAT_REL_BIT]  <= released;
          prdata_ff[ebr_pkg::STAT_BUSY_BIT] <= (state_ff != ebr_pkg::ST_IDLE)
                                               && !released;
          prdata_ff[ebr_pkg::STAT_BUS_REGAIN_REQUEST_BIT] <= !bus_regain_request_n_ff;
          prdata_ff[ebr_pkg::STAT_HOLD_BIT] <= hold_ff;
        end
        default: begin
          prdata_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Ready input path
  // -----------------------------------------------------------------------
  ebr_ready_sync u_ready_sync (
    .sys_clk_in   (sys_clk_in),
    .rst_b_in     (rst_s2_ff),
    .async_sel_in (ctrl_ff[ebr_pkg::CTRL_ASYNC_BIT]),
    .ready_n_in   (ready_n_in),
    .ready_n_out  (ready_n)
  );

  // -----------------------------------------------------------------------
  // Bus cycle sequencer
  // -----------------------------------------------------------------------
  // Next state, evaluated at the end of each output period
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ebr_pkg::ST_IDLE: begin
        if (hold_ff) begin
          nxt_state = ebr_pkg::ST_REL;
        end else if (req_in) begin
          nxt_state = ebr_pkg::ST_ADDR;
        end
      end
      ebr_pkg::ST_ADDR: begin
        if (ctrl_ff[ebr_pkg::CTRL_RWD_BIT]) begin
          nxt_state = ebr_pkg::ST_DLY;
        end else if (waitst_ff != 4'h0) begin
          nxt_state = ebr_pkg::ST_WAIT;
        end else begin
          nxt_state = ebr_pkg::ST_RDY;
        end
      end
      ebr_pkg::ST_DLY: begin
        nxt_state = (waitst_ff != 4'h0) ? ebr_pkg::ST_WAIT : ebr_pkg::ST_RDY;
      end
      ebr_pkg::ST_WAIT: begin
        if (ws_cnt_ff == 4'h1) begin
          nxt_state = ebr_pkg::ST_RDY;
        end
      end
      ebr_pkg::ST_RDY: begin
        if (!ready_n) begin
          if (ctrl_ff[ebr_pkg::CTRL_MUX_BIT]) begin
            nxt_state = ebr_pkg::ST_MUXW;
          end else if (ctrl_ff[ebr_pkg::CTRL_TRI_BIT]) begin
            nxt_state = ebr_pkg::ST_TRIW;
          end else begin
            nxt_state = ebr_pkg::ST_IDLE;
          end
        end
      end
      ebr_pkg::ST_MUXW: begin
        nxt_state = ctrl_ff[ebr_pkg::CTRL_TRI_BIT] ? ebr_pkg::ST_TRIW
                                                   : ebr_pkg::ST_IDLE;
      end
      ebr_pkg::ST_TRIW: begin
        nxt_state = ebr_pkg::ST_IDLE;
      end
      ebr_pkg::ST_REL: begin
        if (!hold_ff) begin
          nxt_state = ebr_pkg::ST_REGAIN;
        end
      end
      ebr_pkg::ST_REGAIN: begin
        nxt_state = ebr_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = ebr_pkg::ST_IDLE;
      end
    endcase
  end

  // State register, advancing once per output period
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      state_ff <= ebr_pkg::ST_IDLE;
    end else if (step) begin
      state_ff <= nxt_state;
    end
  end

  // Memory waitstate counter, loaded on entry to the wait states
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      ws_cnt_ff <= 4'h0;
    end else if (step) begin
      if (nxt_state == ebr_pkg::ST_WAIT && state_ff != ebr_pkg::ST_WAIT) begin
        ws_cnt_ff <= waitst_ff;
      end else if (state_ff == ebr_pkg::ST_WAIT) begin
        ws_cnt_ff <= ws_cnt_ff - 4'h1;
      end
    end
  end

  // Request captured when the cycle starts
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      wr_ff    <= 1'b0;
      addr_ff  <= 16'h0000;
      wdata_ff <= 16'h0000;
    end else if (step && state_ff == ebr_pkg::ST_IDLE &&
                 nxt_state == ebr_pkg::ST_ADDR) begin
      wr_ff    <= req_wr_in;
      addr_ff  <= req_addr_in;
      wdata_ff <= req_wdata_in;
    end
  end

  // Cycle end: read data latched, one-cycle done pulse
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      rdata_ff <= 16'h0000;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= step && state_ff == ebr_pkg::ST_RDY && !ready_n;
      if (step && state_ff == ebr_pkg::ST_RDY && !ready_n && !wr_ff) begin
        rdata_ff <= ext_data_in;
      end
    end
  end

  assign req_done_out  = done_ff;
  assign req_rdata_out = rdata_ff;

  // -----------------------------------------------------------------------
  // Hold arbitration
  // -----------------------------------------------------------------------
  // Hold sampled and handshake outputs changed once per output period
  always_ff @(posedge sys_clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      hold_ff   <= 1'b0;
      bus_release_acknowledge_n_ff <= 1'b1;
      bus_regain_request_n_ff <= 1'b1;
    end else if (step) begin
      hold_ff <= !hold_n_in;
      if (nxt_state == ebr_pkg::ST_REL) begin
        bus_release_acknowledge_n_ff <= 1'b0;
      end else begin
        bus_release_acknowledge_n_ff <= 1'b1;
      end
      // Regain request only signals; hold going high does the regain
      bus_regain_request_n_ff <= !(nxt_state == ebr_pkg::ST_REL && req_in);
    end
  end

  assign bus_release_acknowledge_n_out = bus_release_acknowledge_n_ff;
  assign bus_regain_request_n_out      = bus_regain_request_n_ff;

  // -----------------------------------------------------------------------
  // Pin drivers
  // -----------------------------------------------------------------------
  assign released = (state_ff == ebr_pkg::ST_REL);
  assign cmd_on   = (state_ff == ebr_pkg::ST_WAIT) ||
                    (state_ff == ebr_pkg::ST_RDY)  ||
                    (state_ff == ebr_pkg::ST_DLY &&
                     !ctrl_ff[ebr_pkg::CTRL_RWD_BIT]);

  // Released bus: no line driven, chip select left to its pullup
  assign chip_select_line_oe_out = !released;
  assign ctrl_oe_out             = !released;
  assign ext_addr_oe_out         = !released;
  assign chip_select_line_n_out  = !(state_ff == ebr_pkg::ST_ADDR ||
                                     state_ff == ebr_pkg::ST_DLY  ||
                                     state_ff == ebr_pkg::ST_WAIT ||
                                     state_ff == ebr_pkg::ST_RDY);
  assign cmd_read_n_out          = !(cmd_on && !wr_ff);
  assign cmd_write_n_out         = !(cmd_on && wr_ff);
  assign addr_latch_en_out       = (state_ff == ebr_pkg::ST_ADDR) &&
                                   ctrl_ff[ebr_pkg::CTRL_MUX_BIT];
  assign ext_addr_out            = addr_ff;
  assign ext_data_out            = wdata_ff;
  assign ext_data_oe_out         = cmd_on && wr_ff && !released;

endmodule : ebr_bus_ctrl

/* testbench/ebr_bus_ctrl_props.sv */
// Checker: ownership and command properties of the bus controller
`timescale 1ns/1ps
module ebr_bus_ctrl_props (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_line_n_out,
  input wire logic chip_select_line_oe_out,
  input wire logic cmd_read_n_out,
  input wire logic cmd_write_n_out,
  input wire logic addr_latch_en_out,
  input wire logic system_clock_output_out,
  input wire logic ctrl_oe_out,
  input wire logic ext_addr_oe_out,
  input wire logic ext_data_oe_out,
  input wire logic hold_n_in,
  input wire logic bus_release_acknowledge_n_out,
  input wire logic bus_regain_request_n_out
);
  // ---------------------------------------------------------------
  // Properties on the bus pins
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire logic rel = !bus_release_acknowledge_n_out;

  a_rel_cs_off: assert property (rel |-> !chip_select_line_oe_out)
    else $error("chip select driven while released");
  a_rel_no_drive: assert property
    (rel |-> !(ctrl_oe_out || ext_addr_oe_out || ext_data_oe_out))
    else $error("bus driven while released");
  a_ack_steps: assert property
    ($changed(bus_release_acknowledge_n_out) |=>
     $stable(bus_release_acknowledge_n_out))
    else $error("acknowledge moved off the output clock");
  a_bus_regain_request_steps: assert property
    ($changed(bus_regain_request_n_out) |=>
     $stable(bus_regain_request_n_out))
    else $error("regain request moved off the output clock");
  a_ack_idle: assert property
    ($fell(bus_release_acknowledge_n_out) |-> $past(chip_select_line_n_out))
    else $error("bus handed over inside a cycle");
  a_regain_hold: assert property
    ($rose(bus_release_acknowledge_n_out) |-> $past(hold_n_in))
    else $error("bus regained while hold still low");
  a_drive_first: assert property
    ($fell(chip_select_line_n_out) |-> chip_select_line_oe_out &&
     ctrl_oe_out && ext_addr_oe_out && !rel)
    else $error("cycle started without driving the bus");
  a_cmd_length: assert property
    ($fell(cmd_read_n_out) |=> !cmd_read_n_out && !chip_select_line_n_out)
    else $error("read command shorter than one output clock");
  a_ale_addr: assert property
    (addr_latch_en_out |-> !chip_select_line_n_out && cmd_read_n_out &&
     cmd_write_n_out)
    else $error("address latch pulse outside the address period");
  a_system_clock_output_half: assert property
    (system_clock_output_out |=> !system_clock_output_out)
    else $error("output clock high for more than one system clock");

  c_release: cover property (rel);
  c_regain: cover property ($rose(bus_release_acknowledge_n_out));
  c_bus_regain_request: cover property (rel && !bus_regain_request_n_out);
  c_ale: cover property (addr_latch_en_out);
endmodule : ebr_bus_ctrl_props

bind ebr_bus_ctrl ebr_bus_ctrl_props u_props (
  .sys_clk_in, .rst_b_in, .chip_select_line_n_out, .chip_select_line_oe_out,
  .cmd_read_n_out, .cmd_write_n_out, .addr_latch_en_out,
  .system_clock_output_out, .ctrl_oe_out, .ext_addr_oe_out, .ext_data_oe_out,
  .hold_n_in, .bus_release_acknowledge_n_out, .bus_regain_request_n_out
);

/* testbench/ebr_ext_mem.sv */
// Model of an external memory answering the bus commands
`timescale 1ns/1ps
module ebr_ext_mem (
  input  wire logic        clk_in,
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [3:0]  delay_in,
  output logic      [15:0] rdata_out,
  output logic             ready_n_out
);
  logic [15:0] mem_ff [16];
  logic [15:0] last_ff = 16'h5A5A;
  logic [3:0]  cnt_ff = 4'h0;
  logic        cmd;
  // Command active: selected and reading or writing
  assign cmd = !cs_n_in && !(rd_n_in && wr_n_in);
  // Ready low after the delay, withdrawn when the command ends or, for a nonzero delay, the 4-bit count wraps
  assign ready_n_out = !(cmd && cnt_ff >= delay_in);
  // Released data lines change every cycle
  assign rdata_out = (!cs_n_in && !rd_n_in) ? mem_ff[addr_in[3:0]] : ~last_ff;
  // Preset contents
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_ff[i] = 16'hA500 + 16'(i);
    end
  end
  // Count command cycles, capture written words
  always @(posedge clk_in) begin
    last_ff <= rdata_out;
    cnt_ff <= cmd ? cnt_ff + 4'h1 : 4'h0;
    if (!cs_n_in && !wr_n_in) begin
      mem_ff[addr_in[3:0]] <= wdata_in;
    end
  end
endmodule : ebr_ext_mem

/* testbench/tb_ebr_bus_ctrl.sv */
// Testbench: registers, bus cycles, waitstates and hold arbitration
`timescale 1ns/1ps
module tb_ebr_bus_ctrl;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, req = 1'b0, req_wr = 1'b0, hold_n = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q_r;
  logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, rdata, ea, din, dout;
  logic [3:0] dly = 4'h0;
  logic pready, e_r, e_r_w, done, cs_n, cs_oe, rd_n, wr_n, rdy_n, ack_n;
  logic bus_regain_request_n;
  logic rd_q = 1'b1;
  int fail_count = 0, n_checks = 0, cyc = 0, t_last = 0, t_prev = 0;

  ebr_bus_ctrl uut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(e_r_w), .req_in(req), .req_wr_in(req_wr),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_done_out(done),
    .req_rdata_out(rdata), .system_clock_output_out(),
    .chip_select_line_n_out(cs_n), .chip_select_line_oe_out(cs_oe),
    .cmd_read_n_out(rd_n), .cmd_write_n_out(wr_n), .addr_latch_en_out(),
    .ctrl_oe_out(), .ext_addr_out(ea), .ext_addr_oe_out(),
    .ext_data_in(din), .ext_data_out(dout), .ext_data_oe_out(),
    .ready_n_in(rdy_n), .hold_n_in(hold_n),
    .bus_release_acknowledge_n_out(ack_n),
    .bus_regain_request_n_out(bus_regain_request_n));

  ebr_ext_mem u_mem (.clk_in(clk), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .addr_in(ea), .wdata_in(dout), .delay_in(dly),
    .rdata_out(din), .ready_n_out(rdy_n));

  // Clock, cycle count, read command stamps and timeout
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_q <= rd_n;
    if (rd_q && !rd_n) begin
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (cyc == LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q_r = prdata;
    e_r = e_r_w;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q_r, x);
    chk({31'h0, e_r}, {31'h0, xe});
  endtask : rd

  // One core bus cycle, request dropped when done is seen
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge clk); while (done !== 1'b1);
    req <= 1'b0;
  endtask : xfer

  // Two back-to-back reads; returns cycles between command starts
  task automatic cyc_len(input logic [31:0] c, input logic [31:0] w,
                         output int n);
    apb(1'b1, ebr_pkg::CTRL_OFS, c);
    apb(1'b1, ebr_pkg::WAITST_OFS, w);
    req <= 1'b1;
    req_wr <= 1'b0;
    for (int k = 0; k < 2; k++)
      do @(posedge clk); while (done !== 1'b1);
    req <= 1'b0;
    n = t_last - t_prev;
  endtask : cyc_len

  task automatic until_ack(input logic v);
    for (int i = 0; i < 64 && ack_n !== v; i++) @(posedge clk);
    chk({31'h0, ack_n}, {31'h0, v});
  endtask : until_ack

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int l0;
    int l;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ebr_pkg::CTRL_OFS, 32'h0, 1'b0);
    rd(ebr_pkg::WAITST_OFS, 32'h0, 1'b0);
    apb(1'b1, ebr_pkg::STATUS_OFS, 32'hF);
    rd(ebr_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd(8'h0C, 32'h0, 1'b1);
    // Write and read back in each bus mode, fast and slow responder
    for (int m = 0; m < 4; m++) begin
      dly <= 4'(m * 2 + m / 3);
      apb(1'b1, ebr_pkg::CTRL_OFS, 32'(m * 5 - m / 3 * 5));
      apb(1'b1, ebr_pkg::WAITST_OFS, 32'(m));
      xfer(1'b1, 16'(m), 16'hC0DE ^ 16'(m));
      xfer(1'b0, 16'(m), 16'h0);
      chk({16'h0, rdata}, {16'h0, 16'hC0DE ^ 16'(m)});
      xfer(1'b0, 16'(m + 8), 16'h0);
      chk({16'h0, rdata}, {16'h0, 16'hA508 + 16'(m)});
    end
    // Cycle lengths against the plain demultiplexed cycle
    dly <= 4'h0;
    cyc_len(32'h0, 32'h0, l0);
    cyc_len(32'h1, 32'h0, l);
    chk(32'(l - l0), 32'h2);
    cyc_len(32'h3, 32'h0, l);
    chk(32'(l - l0), 32'h4);
    cyc_len(32'h4, 32'h0, l);
    chk(32'(l - l0), 32'h2);
    cyc_len(32'h0, 32'h3, l);
    chk(32'(l - l0), 32'h6);
    dly <= 4'h5;
    cyc_len(32'h0, 32'h0, l);
    chk(32'(l - l0 >= 4), 32'h1);
    // Hold request during a running cycle, regain request while released
    apb(1'b1, ebr_pkg::CTRL_OFS, 32'h0);
    req <= 1'b1;
    req_wr <= 1'b0;
    req_addr <= 16'h0005;
    do @(posedge clk); while (cs_n !== 1'b0);
    hold_n <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
    chk({31'h0, ack_n}, 32'h1);
    req <= 1'b0;
    until_ack(1'b0);
    chk({31'h0, cs_oe}, 32'h0);
    rd(ebr_pkg::STATUS_OFS, 32'h9, 1'b0);
    req <= 1'b1;
    repeat (12) @(posedge clk);
    chk({31'h0, bus_regain_request_n}, 32'h0);
    chk({31'h0, ack_n}, 32'h0);
    hold_n <= 1'b1;
    until_ack(1'b1);
    do @(posedge clk); while (done !== 1'b1);
    req <= 1'b0;
    chk({31'h0, bus_regain_request_n}, 32'h1);
    // Hold dropped with no regain request
    hold_n <= 1'b0;
    until_ack(1'b0);
    chk({31'h0, bus_regain_request_n}, 32'h1);
    hold_n <= 1'b1;
    until_ack(1'b1);
    xfer(1'b0, 16'h0005, 16'h0);
    chk({16'h0, rdata}, 32'h0000A505);
    give_verdict();
  end
endmodule : tb_ebr_bus_ctrl
